// ==== common/kbm_pkg.sv ====
// package for the emulated keyboard-controller message port
// assumes one bus clock domain plus a sampled 1 MHz tick input
package kbm_pkg;
   localparam logic [7:0] KBM_RESET_BYTE = 8'h00;
   localparam int KBM_STAT_OUT_FULL = 0;
   localparam int KBM_STAT_IN_FULL = 1;
   localparam int KBM_STAT_CMD_DATA = 3;
   localparam int KBM_STAT_AUX = 5;
   localparam int KBM_CLK_HZ = 10000000;
   localparam int KBM_RST_PULSE_US = 6;
   localparam int KBM_FIFO_DEPTH = 16;
   localparam int KBM_DATA_W = 8;

   typedef struct packed {
      logic cmd;
      logic [7:0] data;
   } kbm_host_word_t;

   typedef struct packed {
      logic aux;
      logic [7:0] data;
   } kbm_ec_word_t;

   typedef enum logic [2:0] {
      KBM_PG_IDLE = 3'b001,
      KBM_PG_RUN = 3'b010,
      KBM_PG_DONE = 3'b100
   } kbm_pg_state_t;
endpackage : kbm_pkg

// ==== src/kbm_fifo.sv ====
// parameterised first-in first-out buffer, valid/ready on both sides
// assumes a single clock and active-low asynchronous reset
`timescale 1ns/10ps
module kbm_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_shape
      $error("width below one or depth not a power of two");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic push, pop;
   always_comb begin
      in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
      out_valid = wr_ptr != rd_ptr;
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      next_wr_ptr = wr_ptr + (AW+1)'(push);
      next_rd_ptr = rd_ptr + (AW+1)'(pop);
      out_data = mem[rd_ptr[AW-1:0]];
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
   end
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end
endmodule : kbm_fifo

// ==== src/kbm_msg_port.sv ====
// emulated keyboard-controller message port: host/EC bytes, flags, irqs, cpu reset
// assumes host and EC strobes are one-cycle pulses on clk; tick_1mhz is a pin
//
// Summary of operation
// - system or io-block reset clears every register to 00h, machines idle.
// - host write of data or command raises EC input-full interrupt.
// - host read of normal or aux data raises EC output interrupt.
// - keyboard and mouse host interrupts go out as serial IRQ requests.
// - keyboard reset output goes to pin-function multiplexing.
// - all registers run on the bus clock.
// - cpu-reset counter advances on the separate 1 MHz tick.
// - keyboard output-drain interrupt fires when output-full falls.
// - keyboard input-full interrupt is high while input-full is set.
// - both keyboard buffer interrupts feed aggregated group 19.
// - select bit 0 picks the keyboard host interrupt.
// - select bit 1 picks the mouse host interrupt.
// - no main-power-loss emulation; block just runs on standby power.
// - one message interface and one port-92 sub-block exist.
// - data write clears cmd flag, command write sets it; both set input-full.
// - host data read clears output-full and pending output interrupts.
// - command/data flag is bit 3 of the host status byte.
// - activate enables 1 MHz tick; cleared, gated only when generator idle.
`timescale 1ns/10ps
module kbm_msg_port
   import kbm_pkg::*;
#(
   parameter int PULSE_TICKS = KBM_RST_PULSE_US
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic system_reset_n,
   input wire logic io_block_reset_n,
   input wire logic host_data_wr,
   input wire logic host_cmd_wr,
   input wire logic [7:0] host_wdata,
   input wire logic host_in_ready,
   input wire logic host_data_rd,
   output logic [7:0] host_rdata,
   output logic [7:0] host_status,
   output logic ec_in_valid,
   input wire logic ec_in_ready,
   output kbm_host_word_t ec_in_word,
   input wire logic ec_out_wr,
   input wire logic ec_out_aux,
   input wire logic [7:0] ec_out_data,
   input wire logic activate,
   input wire logic irq_select,
   input wire logic cpu_reset_req,
   input wire logic tick_1mhz,
   output logic ec_input_full_irq,
   output logic ec_output_read_irq,
   output logic kbd_output_drain_irq,
   output logic kbd_input_full_irq,
   output logic [1:0] aggregated_irq_group,
   output logic keyboard_host_irq,
   output logic mouse_host_irq,
   output logic keyboard_reset_out,
   output logic port92_valid
);
   if (PULSE_TICKS < 1 || PULSE_TICKS > 255) begin : g_bad_pulse
      $error("pulse length out of range");
   end

   // combined soft reset: the two block resets synchronised, then ORed in
   logic [1:0] sys_sync, sio_sync;
   logic blk_clr;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sys_sync <= 2'h0;
         sio_sync <= 2'h0;
      end else begin
         sys_sync <= {sys_sync[0], system_reset_n};
         sio_sync <= {sio_sync[0], io_block_reset_n};
      end
   end
   assign blk_clr = !sys_sync[1] || !sio_sync[1];

   // host-to-EC path through the buffer; input-full means bytes waiting
   kbm_host_word_t hw_word;
   logic hw_valid, hw_ready, fifo_out_valid;
   kbm_host_word_t fifo_out;
   always_comb begin
      hw_valid = (host_data_wr || host_cmd_wr) && !blk_clr;
      hw_word.cmd = host_cmd_wr;
      hw_word.data = host_wdata;
   end
   kbm_fifo #(.WIDTH(9), .DEPTH(KBM_FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst_b(rst_b),
      .in_valid(hw_valid),
      .in_ready(hw_ready),
      .in_data(hw_word),
      .out_valid(fifo_out_valid),
      .out_ready(ec_in_ready || blk_clr),
      .out_data(fifo_out)
   );
   always_comb begin
      ec_in_valid = fifo_out_valid && !blk_clr;
      ec_in_word = fifo_out;
   end

   // message registers, all on the bus clock
   logic in_full, cmd_flag, out_full, aux_flag, irq_out_pend;
   logic next_in_full, next_cmd_flag, next_out_full, next_aux_flag, next_irq_out_pend;
   logic [7:0] out_data, next_out_data;
   logic in_irq, out_irq, drain_irq, next_in_irq, next_out_irq, next_drain_irq;
   logic host_wr, host_rd;
   always_comb begin
      host_wr = hw_valid && hw_ready;
      host_rd = host_data_rd && out_full;
      next_in_full = fifo_out_valid;
      next_cmd_flag = cmd_flag;
      if (host_wr) begin
         next_cmd_flag = host_cmd_wr;
         next_in_full = 1'b1;
      end
      next_out_full = out_full;
      next_aux_flag = aux_flag;
      next_out_data = out_data;
      next_irq_out_pend = irq_out_pend;
      if (host_rd) begin
         next_out_full = 1'b0;
         next_irq_out_pend = 1'b0;
      end
      // EC write beats a simultaneous host read: the new byte must not be lost
      if (ec_out_wr) begin
         next_out_full = 1'b1;
         next_aux_flag = ec_out_aux;
         next_out_data = ec_out_data;
         next_irq_out_pend = 1'b1;
      end
      next_in_irq = host_wr;
      next_out_irq = host_data_rd && out_full;
      next_drain_irq = out_full && !next_out_full;
      if (blk_clr) begin
         next_in_full = 1'b0;
         next_cmd_flag = 1'b0;
         next_out_full = 1'b0;
         next_aux_flag = 1'b0;
         next_out_data = KBM_RESET_BYTE;
         next_irq_out_pend = 1'b0;
         next_in_irq = 1'b0;
         next_out_irq = 1'b0;
         next_drain_irq = 1'b0;
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         in_full <= 1'b0;
         cmd_flag <= 1'b0;
         out_full <= 1'b0;
         aux_flag <= 1'b0;
         out_data <= KBM_RESET_BYTE;
         irq_out_pend <= 1'b0;
         in_irq <= 1'b0;
         out_irq <= 1'b0;
         drain_irq <= 1'b0;
      end else begin
         in_full <= next_in_full;
         cmd_flag <= next_cmd_flag;
         out_full <= next_out_full;
         aux_flag <= next_aux_flag;
         out_data <= next_out_data;
         irq_out_pend <= next_irq_out_pend;
         in_irq <= next_in_irq;
         out_irq <= next_out_irq;
         drain_irq <= next_drain_irq;
      end
   end

   always_comb begin
      host_rdata = out_data;
      host_status = 8'h00;
      host_status[KBM_STAT_OUT_FULL] = out_full;
      host_status[KBM_STAT_IN_FULL] = in_full;
      host_status[KBM_STAT_CMD_DATA] = cmd_flag;
      host_status[KBM_STAT_AUX] = aux_flag;
      ec_input_full_irq = in_irq;
      ec_output_read_irq = out_irq;
      kbd_output_drain_irq = drain_irq;
      kbd_input_full_irq = in_full;
      aggregated_irq_group = {drain_irq, in_full};
      // pending output interrupt goes out as a serial irq request
      keyboard_host_irq = irq_out_pend && !irq_select;
      mouse_host_irq = irq_out_pend && irq_select;
   end

   // cpu reset pulse generator; 1 MHz tick comes from outside, so synchronise it
   logic [2:0] tick_sync;
   logic tick_edge, clk_en;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tick_sync <= 3'h0;
      end else begin
         tick_sync <= {tick_sync[1:0], tick_1mhz};
      end
   end
   kbm_pg_state_t pg_state, next_pg_state;
   logic [7:0] pg_count, next_pg_count;
   logic rst_out, next_rst_out;
   always_comb begin
      tick_edge = tick_sync[1] && !tick_sync[2];
      clk_en = activate || pg_state != KBM_PG_IDLE;
      next_pg_state = pg_state;
      next_pg_count = pg_count;
      next_rst_out = 1'b0;
      case (pg_state)
         KBM_PG_IDLE: begin
            next_pg_count = 8'h00;
            if (cpu_reset_req && activate) begin
               next_pg_state = KBM_PG_RUN;
            end
         end
         KBM_PG_RUN: begin
            next_rst_out = 1'b1;
            if (tick_edge && clk_en) begin
               next_pg_count = pg_count + 8'h01;
               if (pg_count + 8'h01 >= 8'(PULSE_TICKS)) begin
                  next_pg_state = KBM_PG_DONE;
                  next_rst_out = 1'b0;
               end
            end
         end
         KBM_PG_DONE: begin
            next_pg_state = KBM_PG_IDLE;
         end
         default: begin
            next_pg_state = KBM_PG_IDLE;
         end
      endcase
      if (blk_clr) begin
         next_pg_state = KBM_PG_IDLE;
         next_pg_count = 8'h00;
         next_rst_out = 1'b0;
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pg_state <= KBM_PG_IDLE;
         pg_count <= 8'h00;
         rst_out <= 1'b0;
      end else begin
         pg_state <= next_pg_state;
         pg_count <= next_pg_count;
         rst_out <= next_rst_out;
      end
   end
   // goes to pin-function mux; active high while pulse runs
   assign keyboard_reset_out = rst_out;

   // single port-92 sub-block: only its valid bit is kept here
   logic p92_valid, next_p92_valid;
   always_comb begin
      next_p92_valid = activate;
      if (blk_clr) begin
         next_p92_valid = 1'b0;
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         p92_valid <= 1'b0;
      end else begin
         p92_valid <= next_p92_valid;
      end
   end
   assign port92_valid = p92_valid;
   // no main-power-loss emulation: nothing watches main power
endmodule : kbm_msg_port

// ==== test/kbm_msg_port_properties.sv ====
// pin-level assertions for the keyboard-controller message port
// assumes bind from the bench top; tick period 8 clocks, PULSE_TICKS 2
`timescale 1ns/10ps
module kbm_msg_port_properties
   import kbm_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic host_data_wr,
   input wire logic host_cmd_wr,
   input wire logic host_data_rd,
   input wire logic [7:0] host_status,
   input wire logic ec_out_wr,
   input wire logic activate,
   input wire logic irq_select,
   input wire logic cpu_reset_req,
   input wire logic ec_input_full_irq,
   input wire logic ec_output_read_irq,
   input wire logic kbd_output_drain_irq,
   input wire logic kbd_input_full_irq,
   input wire logic [1:0] aggregated_irq_group,
   input wire logic keyboard_host_irq,
   input wire logic mouse_host_irq,
   input wire logic keyboard_reset_out
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // an EC write in the same cycle wins, so it is left out
   sequence read_full_s;
      host_data_rd && host_status[KBM_STAT_OUT_FULL] && !ec_out_wr;
   endsequence
   sequence pulse_start_s;
      $rose(cpu_reset_req) && activate && !keyboard_reset_out;
   endsequence
   cmd_write_a: assert property (host_cmd_wr && !host_data_wr |=>
      host_status[KBM_STAT_CMD_DATA] && host_status[KBM_STAT_IN_FULL]) else $error("cmd flag");
   data_write_a: assert property (host_data_wr && !host_cmd_wr |=>
      !host_status[KBM_STAT_CMD_DATA] && host_status[KBM_STAT_IN_FULL]) else $error("data flag");
   write_irq_a: assert property ((host_data_wr || host_cmd_wr) &&
      !host_status[KBM_STAT_IN_FULL] |=> ec_input_full_irq) else $error("no input irq");
   read_irq_a: assert property (read_full_s |=>
      ec_output_read_irq && !host_status[KBM_STAT_OUT_FULL]) else $error("read irq");
   drain_irq_a: assert property (read_full_s |=> ##[0:1] kbd_output_drain_irq)
      else $error("no drain irq");
   idle_read_a: assert property (host_data_rd && !host_status[KBM_STAT_OUT_FULL] |=>
      !ec_output_read_irq) else $error("read irq without data");
   level_irq_a: assert property (kbd_input_full_irq == host_status[KBM_STAT_IN_FULL])
      else $error("input irq level");
   group_map_a: assert property (
      aggregated_irq_group == {kbd_output_drain_irq, kbd_input_full_irq}) else $error("group");
   host_irq_sel_a: assert property ($stable(irq_select) |->
      !(keyboard_host_irq && irq_select) && !(mouse_host_irq && !irq_select)) else $error("sel");
   // output is registered one edge after the generator leaves idle
   pulse_hold_a: assert property (pulse_start_s |=> ##1 keyboard_reset_out[*7])
      else $error("reset pulse short");
   pulse_end_a: assert property ($rose(keyboard_reset_out) |-> ##[8:40] !keyboard_reset_out)
      else $error("reset pulse stuck");
   gated_a: assert property (!activate && !keyboard_reset_out |=> !keyboard_reset_out)
      else $error("pulse while inactive");
endmodule : kbm_msg_port_properties

// ==== test/kbm_ec_model.sv ====
// stand-in for EC firmware draining the host word stream
// assumes the bench drives stall to play a slow firmware
`timescale 1ns/10ps
module kbm_ec_model
   import kbm_pkg::*;
(
   input wire logic clk,
   input wire logic stall,
   input wire logic ec_in_valid,
   input wire kbm_host_word_t ec_in_word,
   output logic ec_in_ready,
   output kbm_host_word_t last_word,
   output int taken
);
   int count = 0;
   assign ec_in_ready = !stall;
   assign taken = count;
   always @(posedge clk) begin
      if (ec_in_valid && ec_in_ready) begin
         last_word <= ec_in_word;
         count <= count + 1;
      end
   end
endmodule : kbm_ec_model

// ==== test/kbm_msg_port_bench.sv ====
// self-checking bench for the keyboard-controller message port
// assumes the EC model in kbm_ec_model.sv and the bound checker
`timescale 1ns/10ps
`define CHK(got, exp) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) begin \
         bad_count++; \
         $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
      end \
   end
module kbm_msg_port_bench
   import kbm_pkg::*;
;
   typedef struct {logic cmd; logic [7:0] data; logic [7:0] status;} kbm_row_t;
   logic clk, rst_b, system_reset_n, io_block_reset_n, host_data_wr, host_cmd_wr, stall;
   logic host_in_ready, host_data_rd, ec_in_valid, ec_in_ready, ec_out_wr, ec_out_aux;
   logic activate, irq_select, cpu_reset_req, tick_1mhz, ec_input_full_irq;
   logic ec_output_read_irq, kbd_output_drain_irq, kbd_input_full_irq, keyboard_host_irq;
   logic mouse_host_irq, keyboard_reset_out, port92_valid;
   logic [7:0] host_wdata, host_rdata, host_status, ec_out_data;
   logic [1:0] aggregated_irq_group;
   kbm_host_word_t ec_in_word, last_word;
   int taken, bad_count, comparisons, i, n;
   kbm_row_t rows [4] = '{'{1, 8'hA5, 8'h0A}, '{0, 8'h00, 8'h02}, '{0, 8'hFF, 8'h02},
      '{1, 8'h5A, 8'h0A}};
   kbm_msg_port #(.PULSE_TICKS(2)) dut_u (.*);
   kbm_ec_model ec_u (.*);
   task automatic pulse(ref logic s);
      @(posedge clk);
      #1 s = 1;
      @(posedge clk);
      #1 s = 0;
   endtask : pulse
   task automatic hw(input logic c, input logic [7:0] d);
      host_wdata = d;
      if (c) pulse(host_cmd_wr);
      else pulse(host_data_wr);
   endtask : hw
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : summarize
   initial begin
      clk = 0;
      forever #50 clk = ~clk;
   end
   // free-running 1.25 MHz source (800 ns period, 8 clocks), unrelated in phase to clk
   initial begin
      tick_1mhz = 0;
      #13;
      forever #400 tick_1mhz = ~tick_1mhz;
   end
   initial begin
      #3000000;
      bad_count++;
      summarize();
   end
   initial begin
      {rst_b, host_data_wr, host_cmd_wr, host_data_rd, ec_out_wr, ec_out_aux} = 0;
      {activate, irq_select, cpu_reset_req, stall, host_in_ready} = 0;
      {system_reset_n, io_block_reset_n, host_wdata, ec_out_data} = 18'h30000;
      repeat (10) @(posedge clk);
      #1 rst_b = 1;
      repeat (3) @(posedge clk);
      #1;
      for (i = 0; i < 4; i++) begin
         hw(rows[i].cmd, rows[i].data);
         `CHK(host_status, rows[i].status)
         `CHK(ec_input_full_irq, 1'b1)
         repeat (4) @(posedge clk);
         #1;
         `CHK(last_word, {rows[i].cmd, rows[i].data})
         `CHK(kbd_input_full_irq, 1'b0)
      end
      $display("table done");
      for (i = 0; i < 2; i++) begin
         irq_select = i[0];
         ec_out_aux = i[0];
         ec_out_data = 8'h3C + i[7:0];
         pulse(ec_out_wr);
         // cmd flag still holds from the last table row, a command write
         `CHK(host_status, i ? 8'h29 : 8'h09)
         `CHK({mouse_host_irq, keyboard_host_irq}, i ? 2'b10 : 2'b01)
         pulse(host_data_rd);
         `CHK(ec_output_read_irq, 1'b1)
         `CHK({mouse_host_irq, keyboard_host_irq, host_status[0]}, 3'b000)
         `CHK(host_rdata, 8'h3C + i[7:0])
         `CHK(kbd_output_drain_irq, 1'b1)
         `CHK(aggregated_irq_group, 2'b10)
         pulse(host_data_rd);
         `CHK(ec_output_read_irq, 1'b0)
      end
      $display("output path done");
      // firmware stalls while the host overruns the 16-word buffer
      stall = 1;
      n = taken;
      for (i = 0; i < 17; i++) hw(0, i[7:0]);
      `CHK(kbd_input_full_irq, 1'b1)
      stall = 0;
      repeat (30) @(posedge clk);
      #1;
      `CHK(taken - n, KBM_FIFO_DEPTH)
      `CHK(last_word, 9'h00F)
      `CHK(host_status[1], 1'b0)
      $display("buffer done");
      cpu_reset_req = 1;
      repeat (20) @(posedge clk);
      #1;
      `CHK(keyboard_reset_out, 1'b0)
      cpu_reset_req = 0;
      activate = 1;
      pulse(cpu_reset_req);
      // reset output is registered one edge after the generator starts
      @(posedge clk);
      #1;
      `CHK(keyboard_reset_out, 1'b1)
      `CHK(port92_valid, 1'b1)
      n = 0;
      while (keyboard_reset_out && n < 100) begin
         @(posedge clk);
         #1;
         n++;
      end
      // two ticks of 8 clocks each, first tick at any phase
      `CHK(n >= 8 && n <= 15, 1'b1)
      $display("cpu reset done");
      stall = 1;
      for (i = 0; i < 2; i++) begin
         pulse(ec_out_wr);
         hw(1, 8'h11);
         {system_reset_n, io_block_reset_n} = i ? 2'b10 : 2'b01;
         repeat (4) @(posedge clk);
         #1 {system_reset_n, io_block_reset_n} = 2'b11;
         repeat (4) @(posedge clk);
         #1;
         `CHK(host_status, KBM_RESET_BYTE)
         `CHK({mouse_host_irq, keyboard_host_irq}, 2'b00)
      end
      stall = 0;
      $display("block reset done");
      summarize();
   end
endmodule : kbm_msg_port_bench
bind kbm_msg_port kbm_msg_port_properties prop_u (.*);
